//--- src/srp_cfg.svh
`ifndef SRP_CFG_SVH
`define SRP_CFG_SVH

// ----------------------------------------------------------------
// Register map and field positions
// ----------------------------------------------------------------
`define SRP_CFG_OFFSET 5'h00 // Serial port configuration register.
`define SRP_KEEP_OFFSET 5'h04 // Register kept through a soft reset.
`define SRP_REG_SLOTS 32 // Register slots held by the port.
`define SRP_DIR_BIT 7 // Read data returned on the data I/O pin.
`define SRP_ORDER_BIT 6 // Bit-order select, one means LSB first.
`define SRP_SOFT_BIT 5 // Soft reset request.
`define SRP_LONG_BIT 4 // Long-instruction select.

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SRP_CFG_RST 8'h00 // Configuration register after reset.
`define SRP_REG_RST 8'h00 // Every other register after reset.

// ----------------------------------------------------------------
// Instruction fields and counts
// ----------------------------------------------------------------
`define SRP_INS_RW_BIT 7 // One reads, zero writes.
`define SRP_LAST_BIT 3'h7 // Bit counter value of a byte's last bit.

`endif

//--- src/srp_pkg.sv
package srp_pkg;

    // ----------------------------------------------------------------
    // Port sequencer states, one-hot.
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SRP_IDLE = 3'b001, // No cycle in progress.
        SRP_INS = 3'b010, // Shifting in the instruction.
        SRP_DATA = 3'b100 // Moving data bytes.
    } srp_phase_e;

    // ----------------------------------------------------------------
    // Whole state of the port, registered as one word.
    // ----------------------------------------------------------------
    typedef struct packed {
        logic sclk_m; // Serial clock, first sync stage.
        logic sclk_s; // Serial clock, second sync stage.
        logic sclk_d; // Serial clock, delayed for edge finding.
        logic cs_m; // Chip select, first sync stage.
        logic cs_s; // Chip select, second sync stage.
        logic di_m; // Data in, first sync stage.
        logic di_s; // Data in, second sync stage.
        logic pm_m; // Pin mode, first sync stage.
        logic pm_s; // Pin mode, second sync stage.
        srp_phase_e st; // Sequencer phase.
        logic [2:0] bit_cnt; // Bits taken in the current byte.
        logic ins_hi; // Upper instruction byte still due.
        logic lng; // Current cycle uses a long instruction.
        logic rw; // Data phase direction, one is read.
        logic [1:0] cnt; // Data bytes left after the current one.
        logic [12:0] addr; // Register address of the current byte.
        logic [7:0] rx; // Receive shifter.
        logic [7:0] tx; // Transmit shifter, bit 7 is on the pin.
        logic dout; // Level driven on the active output pin.
        logic drv; // Port is driving read data.
        logic sdio_oe; // Data I/O pin enable.
        logic out_oe; // Separate output pin enable.
        logic wr_stb; // Register written this cycle.
        logic [4:0] wr_addr; // Address of that write.
        logic [7:0] wr_data; // Value of that write.
        logic [2:0] pin_ctrl; // Direct control levels in pin mode.
        logic [31:0][7:0] regs; // Register space.
    } srp_state_s;

endpackage

//--- src/srp_serial_register_port.sv
// Notes on behaviour
// - First eight rising edges carry a short instruction, sixteen a long one.
// - Data phase moves one to four bytes.
// - Written register updates on the byte's last bit.
// - Chip select high on byte boundary pauses.
// - Chip select high mid-byte abandons the cycle.
// - Instruction bit 7 high reads, low writes.
// - Bits 6 and 5 give byte count minus one.
// - Short instruction bits 4 to 0 address.
// - Long mode uses two bytes, 13-bit address.
// - Bits sampled on serial clock rising edges.
// - Read data changes on rising serial clock.
// - Both data pins released while deselected.
// - Direction bit picks the read data pin.
// - Separate output stays released in single-pin mode.
// - Bit-order select sets MSB or LSB first.
// - MSB first decrements the address.
// - LSB first increments the address.
// - Port configuration changes act immediately.
// - Soft reset clears all but registers 0, 4.
// - Pin mode disables the serial port.
// - Zero bits then zero bytes restore defaults.
`include "srp_cfg.svh"

module srp_serial_register_port #(
    parameter int REG_COUNT = 32, // Registers that answer at the low addresses.
    parameter int ADDR_W = 13 // Width of the long-form address.
) (
    input wire logic ref_clk, // Block clock, 20 MHz.
    input wire logic reset, // Asynchronous reset, active high.
    input wire logic sclk, // Serial clock from the master.
    input wire logic chip_select_n, // Cycle frame, active low.
    input wire logic sdio_in, // Level seen on the data I/O pin.
    input wire logic pin_mode, // High hands the pins to direct control.
    output logic sdio_out, // Data I/O pin output level.
    output logic sdio_oe, // Data I/O pin drive enable.
    output logic serial_data_out, // Separate output pin level.
    output logic serial_data_out_oe, // Separate output pin drive enable.
    output logic reg_wr, // One-cycle pulse per register write.
    output logic [4:0] reg_wr_addr, // Address of the write.
    output logic [7:0] reg_wr_data, // Value written.
    output logic [7:0] serial_port_config, // Configuration register contents.
    output logic [2:0] pin_ctrl // Select, clock, data levels in pin mode.
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    // The state word holds 32 slots and a 13-bit address, so nothing else fits.
    // A smaller register count only narrows the decoded range; all slots stay.
    if (ADDR_W != 13 || REG_COUNT < 5 || REG_COUNT > `SRP_REG_SLOTS)
    begin : g_bad_param
        $error("serial port parameters out of range");
    end

    srp_pkg::srp_state_s state_ff; // Registered state.
    srp_pkg::srp_state_s nxt_state; // Next state.
    logic sclk_rise; // Serial clock rose, seen after the synchronisers.
    logic sclk_fall; // Serial clock fell, seen after the synchronisers.

    // Edges are found only on the second sync stage and its delayed copy.
    // Limitation: each serial clock level must last two ref_clk cycles or more.
    assign sclk_rise = state_ff.sclk_s & ~state_ff.sclk_d;
    assign sclk_fall = ~state_ff.sclk_s & state_ff.sclk_d;

    // ----------------------------------------------------------------
    // Read data fetch
    // ----------------------------------------------------------------
    // Unused addresses read as zero; the byte is turned round for LSB first
    // so that bit 7 of the shifter is always the bit on the pin.
    function automatic logic [7:0] read_byte(input logic [31:0][7:0] regs, input logic [12:0] a,
        input logic lsb);
        logic [7:0] v;
        logic [7:0] r;
        v = (a < 13'(REG_COUNT)) ? regs[a[4:0]] : 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            r[i] = lsb ? v[7 - i] : v[i];
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // The serial clock is far slower than ref_clk, so every serial edge is
    // seen as one ref_clk cycle with sclk_rise or sclk_fall set.
    always_comb
    begin
        logic lsb;
        logic [7:0] rx_new;
        logic [12:0] a_new;
        logic [7:0] tx_sh;
        lsb = 1'b0;
        rx_new = 8'h00;
        a_new = 13'h0000;
        tx_sh = 8'h00;
        nxt_state = state_ff;
        // Two flip-flops on every pin before anything reads it.
        nxt_state.sclk_m = sclk;
        nxt_state.sclk_s = state_ff.sclk_m;
        nxt_state.sclk_d = state_ff.sclk_s;
        nxt_state.cs_m = chip_select_n;
        nxt_state.cs_s = state_ff.cs_m;
        nxt_state.di_m = sdio_in;
        nxt_state.di_s = state_ff.di_m;
        nxt_state.pm_m = pin_mode;
        nxt_state.pm_s = state_ff.pm_m;
        nxt_state.wr_stb = 1'b0;
        lsb = state_ff.regs[`SRP_CFG_OFFSET][`SRP_ORDER_BIT];
        // Data in travels the same sync depth as the clock, so it lines up.
        rx_new = lsb ? {state_ff.di_s, state_ff.rx[7:1]} : {state_ff.rx[6:0], state_ff.di_s};
        a_new = state_ff.addr;
        tx_sh = {state_ff.tx[6:0], 1'b0};
        if (state_ff.pm_s)
        begin
            // Pin mode: the port sleeps and the pins become control levels.
            nxt_state.st = srp_pkg::SRP_IDLE;
            nxt_state.bit_cnt = 3'h0;
            nxt_state.drv = 1'b0;
            nxt_state.pin_ctrl = {state_ff.cs_s, state_ff.sclk_s, state_ff.di_s};
        end
        else if (state_ff.cs_s)
        begin
            // Deselected: release the pins in every case.
            nxt_state.drv = 1'b0;
            if (state_ff.bit_cnt != 3'h0)
            begin
                // A byte was cut short, so the cycle is dropped.
                nxt_state.st = srp_pkg::SRP_IDLE;
                nxt_state.bit_cnt = 3'h0;
            end
            // On a byte boundary all other state is held for the resume.
        end
        else
        begin
            case (state_ff.st)
                srp_pkg::SRP_IDLE:
                begin
                    // Idle with select low, also right after a cycle ends: instruction length is fixed for the next cycle.
                    nxt_state.st = srp_pkg::SRP_INS;
                    nxt_state.ins_hi = state_ff.regs[`SRP_CFG_OFFSET][`SRP_LONG_BIT];
                    nxt_state.lng = state_ff.regs[`SRP_CFG_OFFSET][`SRP_LONG_BIT];
                    nxt_state.bit_cnt = 3'h0;
                end
                srp_pkg::SRP_INS:
                begin
                    if (sclk_rise)
                    begin
                        nxt_state.rx = rx_new;
                        nxt_state.bit_cnt = state_ff.bit_cnt + 3'h1;
                        if (state_ff.bit_cnt == `SRP_LAST_BIT)
                        begin
                            if (state_ff.ins_hi)
                            begin
                                // Upper long byte: direction, count, top address bits.
                                nxt_state.rw = rx_new[`SRP_INS_RW_BIT];
                                nxt_state.cnt = rx_new[6:5];
                                nxt_state.addr = {rx_new[4:0], 8'h00};
                                nxt_state.ins_hi = 1'b0;
                            end
                            else
                            begin
                                if (state_ff.lng)
                                begin
                                    a_new = {state_ff.addr[12:8], rx_new};
                                end
                                else
                                begin
                                    nxt_state.rw = rx_new[`SRP_INS_RW_BIT];
                                    nxt_state.cnt = rx_new[6:5];
                                    a_new = {8'h00, rx_new[4:0]};
                                end
                                // Eighth edge of the last instruction byte ends the instruction; first read byte loads.
                                nxt_state.addr = a_new;
                                nxt_state.st = srp_pkg::SRP_DATA;
                                nxt_state.tx = read_byte(state_ff.regs, a_new, lsb);
                                nxt_state.dout = nxt_state.tx[7];
                            end
                        end
                    end
                end
                srp_pkg::SRP_DATA:
                begin
                    // Drive starts on a falling edge so the master has turned round.
                    if (sclk_fall && state_ff.rw)
                    begin
                        nxt_state.drv = 1'b1;
                    end
                    if (sclk_rise)
                    begin
                        nxt_state.rx = rx_new;
                        nxt_state.bit_cnt = state_ff.bit_cnt + 3'h1;
                        nxt_state.tx = tx_sh;
                        nxt_state.dout = tx_sh[7];
                        if (state_ff.bit_cnt == `SRP_LAST_BIT)
                        begin
                            if (!state_ff.rw && state_ff.addr < 13'(REG_COUNT))
                            begin
                                // The write lands on the byte's last bit.
                                nxt_state.regs[state_ff.addr[4:0]] = rx_new;
                                nxt_state.wr_stb = 1'b1;
                                nxt_state.wr_addr = state_ff.addr[4:0];
                                nxt_state.wr_data = rx_new;
                                if (state_ff.addr[4:0] == `SRP_CFG_OFFSET && rx_new[`SRP_SOFT_BIT])
                                begin
                                    // Soft reset bit clears itself once acted on.
                                    nxt_state.regs[`SRP_CFG_OFFSET][`SRP_SOFT_BIT] = 1'b0;
                                    for (int i = 1; i < `SRP_REG_SLOTS; i++)
                                    begin
                                        if (i != `SRP_KEEP_OFFSET)
                                        begin
                                            nxt_state.regs[i] = `SRP_REG_RST;
                                        end
                                    end
                                end
                            end
                            // The step uses the configuration just written.
                            if (nxt_state.regs[`SRP_CFG_OFFSET][`SRP_ORDER_BIT])
                            begin
                                a_new = state_ff.addr + 13'h0001;
                            end
                            else
                            begin
                                a_new = state_ff.addr - 13'h0001;
                            end
                            nxt_state.addr = a_new;
                            if (state_ff.cnt == 2'h0)
                            begin
                                // Last byte done: the cycle is over.
                                nxt_state.st = srp_pkg::SRP_IDLE;
                                nxt_state.drv = 1'b0;
                            end
                            else
                            begin
                                nxt_state.cnt = state_ff.cnt - 2'h1;
                                nxt_state.tx = read_byte(state_ff.regs, a_new,
                                    nxt_state.regs[`SRP_CFG_OFFSET][`SRP_ORDER_BIT]);
                                nxt_state.dout = nxt_state.tx[7];
                            end
                        end
                    end
                end
                default:
                begin
                    nxt_state.st = srp_pkg::SRP_IDLE;
                end
            endcase
        end
        // Only the pin picked by the direction bit is ever driven.
        nxt_state.sdio_oe = nxt_state.drv & nxt_state.regs[`SRP_CFG_OFFSET][`SRP_DIR_BIT];
        nxt_state.out_oe = nxt_state.drv & ~nxt_state.regs[`SRP_CFG_OFFSET][`SRP_DIR_BIT];
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Later assignments in the reset branch override the blanket clear.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_ff <= '0;
            state_ff.st <= srp_pkg::SRP_IDLE;
            state_ff.cs_m <= 1'b1;
            state_ff.cs_s <= 1'b1;
            state_ff.regs <= {`SRP_REG_SLOTS{`SRP_REG_RST}};
            state_ff.regs[`SRP_CFG_OFFSET] <= `SRP_CFG_RST;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Every output is a field of the state register.
    assign sdio_out = state_ff.dout;
    assign sdio_oe = state_ff.sdio_oe;
    assign serial_data_out = state_ff.dout;
    assign serial_data_out_oe = state_ff.out_oe;
    assign reg_wr = state_ff.wr_stb;
    assign reg_wr_addr = state_ff.wr_addr;
    assign reg_wr_data = state_ff.wr_data;
    assign serial_port_config = state_ff.regs[`SRP_CFG_OFFSET];
    assign pin_ctrl = state_ff.pin_ctrl;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // All checks run on ref_clk and stay quiet while reset is high.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence s_last_bit;
        sclk_rise && state_ff.bit_cnt == `SRP_LAST_BIT && !state_ff.cs_s && !state_ff.pm_s;
    endsequence

    sequence s_read_fall;
        state_ff.st == srp_pkg::SRP_DATA && state_ff.rw && sclk_fall && !state_ff.cs_s && !state_ff.pm_s;
    endsequence

    cs_release_a: assert property (state_ff.cs_s |=> !sdio_oe && !serial_data_out_oe)
        else $error("data pins driven while deselected");
    pin_pick_a: assert property (sdio_oe |-> serial_port_config[`SRP_DIR_BIT] && !serial_data_out_oe)
        else $error("wrong pin driven for read data");
    abort_a: assert property ((state_ff.cs_s && !state_ff.pm_s && state_ff.bit_cnt != 3'h0)
        |=> state_ff.st == srp_pkg::SRP_IDLE)
        else $error("partial byte did not abandon the cycle");
    pause_hold_a: assert property ((state_ff.cs_s && !state_ff.pm_s && state_ff.bit_cnt == 3'h0)
        |=> $stable(state_ff.st) && $stable(state_ff.addr) && $stable(state_ff.cnt))
        else $error("pause lost the cycle state");
    ins_end_a: assert property ((state_ff.st == srp_pkg::SRP_INS && !state_ff.ins_hi) ##0 s_last_bit
        |=> state_ff.st == srp_pkg::SRP_DATA)
        else $error("instruction did not end on its eighth bit");
    write_now_a: assert property ((state_ff.st == srp_pkg::SRP_DATA && !state_ff.rw
        && state_ff.addr < 13'(REG_COUNT)) ##0 s_last_bit
        |=> reg_wr && reg_wr_addr == $past(state_ff.addr[4:0]))
        else $error("write did not land on the last bit");
    count_end_a: assert property ((state_ff.st == srp_pkg::SRP_DATA && state_ff.cnt == 2'h0) ##0 s_last_bit
        |=> state_ff.st == srp_pkg::SRP_IDLE)
        else $error("data phase did not end after its byte count");
    addr_step_a: assert property ((state_ff.st == srp_pkg::SRP_DATA && state_ff.rw && state_ff.cnt != 2'h0)
        ##0 s_last_bit |=> state_ff.addr == (serial_port_config[`SRP_ORDER_BIT]
        ? $past(state_ff.addr) + 13'h0001 : $past(state_ff.addr) - 13'h0001))
        else $error("address step in the wrong direction");
    pin_mode_a: assert property (state_ff.pm_s |=> state_ff.st == srp_pkg::SRP_IDLE
        && !sdio_oe && !serial_data_out_oe)
        else $error("serial port active in pin mode");
    soft_reset_a: assert property ((reg_wr && reg_wr_addr == `SRP_CFG_OFFSET && reg_wr_data[`SRP_SOFT_BIT])
        |-> state_ff.regs[1] == `SRP_REG_RST && $stable(state_ff.regs[`SRP_KEEP_OFFSET]))
        else $error("soft reset did not restore defaults");
    read_drive_a: assert property (s_read_fall |=> sdio_oe || serial_data_out_oe)
        else $error("read data not driven after the falling edge");

endmodule

//--- tb/srp_spi_master.sv
module srp_spi_master (
    input wire logic ref_clk, // Paces the link, 8 cycles per bit.
    input wire logic sdio_out, // Port drive on the data I/O pin.
    input wire logic sdio_oe, // Port enable on the data I/O pin.
    input wire logic serial_data_out, // Separate output pin level.
    input wire logic serial_data_out_oe, // Separate output pin enable.
    output logic sclk = 1'b0, // Serial clock, low outside frames.
    output logic chip_select_n = 1'b1, // Frame, active low.
    output logic sdio_in // Resolved data I/O line.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic m_do = 1'b0; // Master drive level.
    logic m_oe = 1'b0; // Master drives the data I/O line.
    logic last = 1'b0; // Last line level, inverted when nobody drives.
    logic [7:0] wbuf [4]; // Bytes to write.
    logic [7:0] rbuf [4]; // Bytes read back.
    // A floating line toggles so that a stale value is never mistaken for data.
    always_comb sdio_in = sdio_oe ? sdio_out : (m_oe ? m_do : ~last);
    always @(posedge ref_clk) last <= sdio_in;
    // One 400 ns bit: data changes with the fall and is read in mid-high.
    task automatic bitx(input logic b, input logic drv, input logic one, output logic r);
        @(negedge ref_clk);
        sclk = 1'b0;
        m_do = b;
        m_oe = drv;
        repeat (4) @(negedge ref_clk);
        sclk = 1'b1;
        repeat (2) @(negedge ref_clk);
        r = one ? (sdio_oe ? sdio_out : 1'bz) : (serial_data_out_oe ? serial_data_out : 1'bz);
        @(negedge ref_clk);
    endtask
    task automatic xbyte(input logic [7:0] v, input logic drv, input logic lsb, input logic one, output logic [7:0] r);
        logic b;
        for (int i = 0; i < 8; i++)
        begin
            bitx(v[lsb ? i : 7 - i], drv, one, b);
            r[lsb ? i : 7 - i] = b;
        end
    endtask
    // Short instruction only; the long form is never selected.
    task automatic frame(input logic [7:0] ins, input int n, input logic lsb, input logic one, input logic pause);
        logic [7:0] r;
        @(negedge ref_clk);
        chip_select_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        xbyte(ins, 1'b1, lsb, one, r);
        for (int k = 0; k < n; k++)
        begin
            if (pause)
            begin
                chip_select_n = 1'b1;
                repeat (8) @(negedge ref_clk);
                chip_select_n = 1'b0;
                repeat (3) @(negedge ref_clk);
            end
            xbyte(wbuf[k], !ins[7], lsb, one, r);
            rbuf[k] = r;
        end
        @(negedge ref_clk);
        sclk = 1'b0;
        m_oe = 1'b0;
        repeat (2) @(negedge ref_clk);
        chip_select_n = 1'b1;
        repeat (6) @(negedge ref_clk);
    endtask
    // Zero bits then a raised select, leaving the byte unfinished.
    task automatic partial(input int nb);
        logic r;
        @(negedge ref_clk);
        chip_select_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        for (int i = 0; i < nb; i++)
            bitx(1'b0, 1'b1, 1'b0, r);
        chip_select_n = 1'b1;
        sclk = 1'b0;
        repeat (6) @(negedge ref_clk);
    endtask
endmodule

//--- tb/test_serial_register_port.sv
module test_serial_register_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0; // Block clock, 50 ns.
    logic reset = 1'b1; // Held for 20 cycles.
    logic pin_mode = 1'b0; // Serial port enabled.
    logic sclk, chip_select_n, sdio_in, sdio_out, sdio_oe, serial_data_out, serial_data_out_oe, reg_wr;
    logic [4:0] reg_wr_addr;
    logic [7:0] reg_wr_data, serial_port_config;
    logic [2:0] pin_ctrl;
    logic [12:0] wlog [$]; // Register writes in order.
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    srp_serial_register_port u_srp_serial_register_port (.ref_clk(ref_clk), .reset(reset), .sclk(sclk),
        .chip_select_n(chip_select_n), .sdio_in(sdio_in), .pin_mode(pin_mode), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
        .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
        .serial_port_config(serial_port_config), .pin_ctrl(pin_ctrl));
    srp_spi_master u_srp_spi_master (.ref_clk(ref_clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe), .sclk(sclk),
        .chip_select_n(chip_select_n), .sdio_in(sdio_in));
    initial forever #25 ref_clk = ~ref_clk;
    always @(negedge ref_clk) if (reg_wr === 1'b1) wlog.push_back({reg_wr_addr, reg_wr_data});
    // The whole run needs about 3000 cycles; a hang is cut short well above that.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            conclude();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wexp(input logic [12:0] e);
        logic [12:0] s;
        s = 'x;
        if (wlog.size() > 0) s = wlog.pop_front();
        check({3'h0, s}, {3'h0, e});
    endtask
    task automatic wr1(input logic [7:0] ins, input logic [7:0] v, input logic lsb);
        u_srp_spi_master.wbuf[0] = v;
        u_srp_spi_master.frame(ins, 1, lsb, 1'b0, 1'b0);
        wexp({ins[4:0], v});
    endtask
    // Four bytes with pauses, then every count code read back.
    task automatic t_burst();
        logic [7:0] ex [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
        check({14'h0, sdio_oe, serial_data_out_oe}, 16'h0000);
        u_srp_spi_master.wbuf = ex;
        u_srp_spi_master.frame(8'h65, 4, 1'b0, 1'b0, 1'b1);
        for (int k = 0; k < 4; k++) wexp({5'h05 - 5'(k), ex[k]});
        for (int c = 0; c < 4; c++)
        begin
            u_srp_spi_master.frame({1'b1, 2'(c), 5'h05}, c + 1, 1'b0, 1'b0, 1'b0);
            for (int k = 0; k <= c; k++) check({8'h0, u_srp_spi_master.rbuf[k]}, {8'h0, ex[k]});
        end
        check(16'(wlog.size()), 16'h0000);
    endtask
    // A broken byte, then a clean write.
    task automatic t_abort();
        u_srp_spi_master.partial(4);
        wr1(8'h0C, 8'h5A, 1'b0);
    endtask
    // LSB first, then single-pin reads, then soft reset.
    task automatic t_order();
        wr1(8'h00, 8'h40, 1'b0);
        check({8'h0, serial_port_config}, 16'h0040);
        u_srp_spi_master.wbuf[0] = 8'h66;
        u_srp_spi_master.wbuf[1] = 8'h77;
        u_srp_spi_master.frame(8'h30, 2, 1'b1, 1'b0, 1'b0);
        wexp({5'h10, 8'h66});
        wexp({5'h11, 8'h77});
        wr1(8'h00, 8'hC0, 1'b1);
        u_srp_spi_master.frame(8'hB0, 2, 1'b1, 1'b1, 1'b0);
        check({u_srp_spi_master.rbuf[0], u_srp_spi_master.rbuf[1]}, 16'h6677);
        wr1(8'h00, 8'h20, 1'b1);
        check({8'h0, serial_port_config}, 16'h0000);
        u_srp_spi_master.frame(8'hA5, 2, 1'b0, 1'b0, 1'b0);
        check({u_srp_spi_master.rbuf[0], u_srp_spi_master.rbuf[1]}, 16'h0022);
    endtask
    // Recovery sequence from LSB-first mode, then pin mode.
    task automatic t_recover();
        wr1(8'h00, 8'h40, 1'b0);
        u_srp_spi_master.partial(5);
        wr1(8'h00, 8'h00, 1'b1);
        check({8'h0, serial_port_config}, 16'h0000);
        pin_mode = 1'b1;
        u_srp_spi_master.wbuf[0] = 8'h99;
        u_srp_spi_master.frame(8'h06, 1, 1'b0, 1'b0, 1'b0);
        check({14'h0, pin_ctrl[2:1]}, 16'h0002);
        pin_mode = 1'b0;
        check(16'(wlog.size()), 16'h0000);
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(negedge ref_clk);
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
        t_burst();
        t_abort();
        t_order();
        t_recover();
        conclude();
    end
endmodule
